//--- verilog/ipd_pkg.sv
// Shared constants and types for the indexed postbyte decoder
package ipd_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_ACC    = 6'h00;
	localparam logic [5:0] ADDR_IDXX   = 6'h04;
	localparam logic [5:0] ADDR_IDXY   = 6'h08;
	localparam logic [5:0] ADDR_STK    = 6'h0C;
	localparam logic [5:0] ADDR_PC     = 6'h10;
	localparam logic [5:0] ADDR_FLAGS  = 6'h14;
	localparam logic [5:0] ADDR_CTRL   = 6'h18;
	localparam logic [5:0] ADDR_EA     = 6'h1C;
	localparam logic [5:0] ADDR_STATUS = 6'h20;
	localparam logic [5:0] ADDR_OPND   = 6'h24;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [7:0]  RST_FLAGS = 8'h00;

	// ----------------------------------------------------------------
	// Flag register bit positions
	// ----------------------------------------------------------------
	localparam int FLG_C = 0;
	localparam int FLG_V = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam int FLG_I = 4;
	localparam int FLG_H = 5;
	localparam int FLG_X = 6;
	localparam int FLG_S = 7;

	// ----------------------------------------------------------------
	// Control and status fields
	// ----------------------------------------------------------------
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_COND_LSB = 4;
	localparam int CTL_GO       = 8;
	localparam int ST_DONE      = 0;
	localparam int ST_PAGE2     = 1;
	localparam int ST_INDIR     = 2;
	localparam int ST_BRANCH    = 3;
	localparam int ST_BUSY      = 4;
	localparam int ST_FORM_LSB  = 5;
	localparam int ST_OPC_LSB   = 8;
	localparam int ST_PB_LSB    = 16;

	// ----------------------------------------------------------------
	// Operand modes, index forms, branch conditions
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_IMPLIED_OPERAND = 3'h0;
	localparam logic [2:0] MODE_LITERAL_BYTE    = 3'h1;
	localparam logic [2:0] MODE_LITERAL_WORD    = 3'h2;
	localparam logic [2:0] MODE_DIRECT          = 3'h3;
	localparam logic [2:0] MODE_FULL_ADDRESS    = 3'h4;
	localparam logic [2:0] MODE_REL_BYTE        = 3'h5;
	localparam logic [2:0] MODE_REL_WORD        = 3'h6;
	localparam logic [2:0] MODE_INDEXED         = 3'h7;
	localparam logic [1:0] FORM_REGISTER_OFFSET = 2'h0;
	localparam logic [1:0] FORM_NINE_BIT_OFFSET = 2'h1;
	localparam logic [1:0] FORM_WIDE_OFFSET     = 2'h2;
	localparam logic [2:0] COND_ALWAYS = 3'h0;
	localparam logic [2:0] COND_ZSET   = 3'h1;
	localparam logic [2:0] COND_ZCLR   = 3'h2;
	localparam logic [2:0] COND_NSET   = 3'h3;
	localparam logic [2:0] COND_VSET   = 3'h4;
	localparam logic [2:0] COND_CSET   = 3'h5;
	localparam logic [2:0] COND_CCLR   = 3'h6;

	localparam logic [7:0] PAGE2_PREFIX = 8'h18;
	localparam logic [2:0] QUEUE_DEPTH  = 3'h4;
	localparam logic [2:0] QUEUE_START  = 3'h3;

	typedef enum logic [2:0] {
		S_IDLE, S_OPC, S_POST, S_HI_BYTE, S_LO_BYTE, S_FINISH
	} ipd_state_t;

endpackage : ipd_pkg

//--- verilog/ipd_decoder.sv
// Indexed postbyte decoder with programming model and Avalon-MM slave
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
module ipd_decoder
	import ipd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  prog_byte,
	input  wire logic        prog_valid,
	output logic             prog_ready,
	output logic      [15:0] fetch_addr
);

	function automatic logic [15:0] ipd_merge(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  be
	);
		ipd_merge = {be[1] ? new_v[15:8] : old_v[15:8],
			be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : ipd_merge

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ipd_state_t  st_q, st_d;
	logic        wait_q;
	logic [31:0] rdata_q, rdata_w;
	logic [7:0]  acc_a_q, acc_b_q, flags_q;
	logic [15:0] reg_x_q, reg_y_q, stk_q, pc_q, fetch_q;
	logic [15:0] ea_q, opnd_q, opnd_d;
	logic [7:0]  opc_q, pb_q;
	logic [2:0]  mode_q, cond_q;
	logic [1:0]  form_q;
	logic        go_q, done_q, page2_q, indir_q, branch_q, ready_q;
	logic [7:0]  q_mem [4];
	logic [1:0]  wp_q, rp_q;
	logic [2:0]  cnt_q, cnt_d;

	// ----------------------------------------------------------------
	// Bus slave: one wait cycle, then the access completes
	// ----------------------------------------------------------------
	wire req    = avs_read | avs_write;
	wire wr_go  = avs_write & ~wait_q;
	wire rd_cap = avs_read & wait_q;
	wire wait_d = wait_q ? ~req : 1'b1;
	wire [15:0] wd16 = avs_writedata[15:0];
	wire [1:0]  be16 = avs_byteenable[1:0];
	wire w_acc   = wr_go && avs_address == ADDR_ACC;
	wire w_x     = wr_go && avs_address == ADDR_IDXX;
	wire w_y     = wr_go && avs_address == ADDR_IDXY;
	wire w_stk   = wr_go && avs_address == ADDR_STK;
	wire w_pc    = wr_go && avs_address == ADDR_PC;
	wire w_flags = wr_go && avs_address == ADDR_FLAGS && be16[0];
	wire w_ctrl  = wr_go && avs_address == ADDR_CTRL && be16[0];
	wire go_wr   = w_ctrl && be16[1] && avs_writedata[CTL_GO];
	// A new PC restarts fetching; queued bytes are stale
	wire flush   = w_pc;

	// ----------------------------------------------------------------
	// Instruction queue
	// ----------------------------------------------------------------
	wire [7:0] head = q_mem[rp_q];
	wire push = prog_valid & ready_q;
	wire fetching = st_q == S_OPC || st_q == S_POST
		|| st_q == S_HI_BYTE || st_q == S_LO_BYTE;
	wire pop = fetching && cnt_q != 3'h0 && !flush;
	wire [15:0] pc_merge = ipd_merge(pc_q, wd16, be16);

	always_comb begin
		cnt_d = cnt_q;
		if (flush) begin
			cnt_d = 3'h0;
		end else if (push && !pop) begin
			cnt_d = cnt_q + 3'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			q_mem[wp_q] <= prog_byte;
		end
	end

	// ----------------------------------------------------------------
	// Postbyte decode and effective address
	// ----------------------------------------------------------------
	wire f_long  = pb_q[7:5] == 3'b111;
	wire is_acc  = f_long & pb_q[2];
	wire is_cst  = f_long & ~pb_q[2];
	wire is_off5 = ~f_long & ~pb_q[5];
	wire is_auto = ~f_long & pb_q[5];
	wire is_ind  = f_long & pb_q[1] & pb_q[0];
	wire is_post = is_auto & pb_q[4];
	wire [1:0] rr = f_long ? pb_q[4:3] : pb_q[7:6];
	wire [15:0] acc_d16 = {acc_a_q, acc_b_q};
	logic [15:0] base_w, off_w, ea_w;

	assign base_w = rr == 2'h0 ? reg_x_q : rr == 2'h1 ? reg_y_q
		: rr == 2'h2 ? stk_q : pc_q;
	wire [15:0] adj_w = pb_q[3] ? {12'hFFF, pb_q[3:0]}
		: {12'h000, pb_q[3:0]} + 16'h0001;
	wire [15:0] adjd_w = base_w + adj_w;
	wire [15:0] cst_w = pb_q[1] ? opnd_q : {{8{pb_q[0]}}, opnd_q[7:0]};
	wire [15:0] accoff_w = pb_q[1] ? acc_d16
		: {8'h00, pb_q[0] ? acc_b_q : acc_a_q};
	wire [15:0] off5_w = {{11{pb_q[4]}}, pb_q[4:0]};
	assign off_w = is_off5 ? off5_w : is_auto ? adj_w
		: is_acc ? accoff_w : cst_w;
	wire [15:0] ndx_ea = is_post ? base_w : base_w + off_w;

	always_comb begin
		case (mode_q)
			MODE_DIRECT:       ea_w = {8'h00, opnd_q[7:0]};
			MODE_FULL_ADDRESS: ea_w = opnd_q;
			MODE_REL_BYTE:     ea_w = pc_q + {{8{opnd_q[7]}}, opnd_q[7:0]};
			MODE_REL_WORD:     ea_w = pc_q + opnd_q;
			MODE_INDEXED:      ea_w = ndx_ea;
			default:           ea_w = RST_WORD;
		endcase
	end

	// branch test on N Z V C
	logic cond_w;
	always_comb begin
		case (cond_q)
			COND_ALWAYS: cond_w = 1'b1;
			COND_ZSET:   cond_w = flags_q[FLG_Z];
			COND_ZCLR:   cond_w = ~flags_q[FLG_Z];
			COND_NSET:   cond_w = flags_q[FLG_N];
			COND_VSET:   cond_w = flags_q[FLG_V];
			COND_CSET:   cond_w = flags_q[FLG_C];
			COND_CCLR:   cond_w = ~flags_q[FLG_C];
			default:     cond_w = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	wire fin = st_q == S_FINISH;
	wire start = st_q == S_IDLE && st_d == S_OPC;
	wire is_prefix = head == PAGE2_PREFIX && !page2_q;
	wire post_wide = head[7:5] == 3'b111 && !head[2];
	wire mod_en = fin && mode_q == MODE_INDEXED && is_auto;

	always_comb begin
		st_d = st_q;
		case (st_q)
			S_IDLE: if (go_q && cnt_q >= QUEUE_START) begin
				st_d = S_OPC;
			end
			S_OPC: if (pop && !is_prefix) begin
				case (mode_q)
					MODE_IMPLIED_OPERAND: st_d = S_FINISH;
					MODE_LITERAL_BYTE,
					MODE_DIRECT,
					MODE_REL_BYTE:        st_d = S_LO_BYTE;
					MODE_INDEXED:         st_d = S_POST;
					default:              st_d = S_HI_BYTE;
				endcase
			end
			S_POST: if (pop) begin
				st_d = !post_wide ? S_FINISH
					: head[1] ? S_HI_BYTE : S_LO_BYTE;
			end
			S_HI_BYTE: if (pop) begin
				st_d = S_LO_BYTE;
			end
			S_LO_BYTE: if (pop) begin
				st_d = S_FINISH;
			end
			S_FINISH: st_d = S_IDLE;
			default:  st_d = S_IDLE;
		endcase
		if (flush) begin
			st_d = S_IDLE;
		end
	end

	always_comb begin
		opnd_d = opnd_q;
		if (pop && st_q == S_OPC) begin
			opnd_d = RST_WORD;
		end else if (pop && st_q == S_HI_BYTE) begin
			opnd_d[15:8] = head;
		end else if (pop && st_q == S_LO_BYTE) begin
			opnd_d[7:0] = head;
		end
	end

	// ----------------------------------------------------------------
	// Programming model next values
	// ----------------------------------------------------------------
	// write back the adjusted register
	wire [15:0] x_d = mod_en && rr == 2'h0 ? adjd_w
		: w_x ? ipd_merge(reg_x_q, wd16, be16) : reg_x_q;
	wire [15:0] y_d = mod_en && rr == 2'h1 ? adjd_w
		: w_y ? ipd_merge(reg_y_q, wd16, be16) : reg_y_q;
	wire [15:0] stk_d = mod_en && rr == 2'h2 ? adjd_w
		: w_stk ? ipd_merge(stk_q, wd16, be16) : stk_q;
	wire [15:0] pc_d = flush ? pc_merge
		: pop ? pc_q + 16'h0001 : pc_q;
	wire [15:0] fetch_d = flush ? pc_merge
		: push ? fetch_q + 16'h0001 : fetch_q;
	wire [7:0] a_d = w_acc && be16[1] ? wd16[15:8] : acc_a_q;
	wire [7:0] b_d = w_acc && be16[0] ? wd16[7:0] : acc_b_q;
	wire [1:0] form_d = !is_cst ? FORM_REGISTER_OFFSET
		: pb_q[1] ? FORM_WIDE_OFFSET : FORM_NINE_BIT_OFFSET;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdata_w = 32'h0000_0000;
		case (avs_address)
			ADDR_ACC:    rdata_w[15:0] = acc_d16;
			ADDR_IDXX:   rdata_w[15:0] = reg_x_q;
			ADDR_IDXY:   rdata_w[15:0] = reg_y_q;
			ADDR_STK:    rdata_w[15:0] = stk_q;
			ADDR_PC:     rdata_w[15:0] = pc_q;
			ADDR_FLAGS:  rdata_w[7:0] = flags_q;
			ADDR_CTRL: begin
				rdata_w[CTL_MODE_LSB +: 3] = mode_q;
				rdata_w[CTL_COND_LSB +: 3] = cond_q;
			end
			ADDR_EA:     rdata_w[15:0] = ea_q;
			ADDR_STATUS: begin
				rdata_w[ST_DONE]   = done_q;
				rdata_w[ST_PAGE2]  = page2_q;
				rdata_w[ST_INDIR]  = indir_q;
				rdata_w[ST_BRANCH] = branch_q;
				rdata_w[ST_BUSY]   = go_q | st_q != S_IDLE;
				rdata_w[ST_FORM_LSB +: 2] = form_q;
				rdata_w[ST_OPC_LSB +: 8]  = opc_q;
				rdata_w[ST_PB_LSB +: 8]   = pb_q;
			end
			ADDR_OPND:   rdata_w[15:0] = opnd_q;
			default:     rdata_w = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
			wp_q    <= 2'h0;
			rp_q    <= 2'h0;
			cnt_q   <= 3'h0;
			ready_q <= 1'b0;
			fetch_q <= RST_WORD;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rd_cap ? rdata_w : rdata_q;
			wp_q    <= flush ? 2'h0 : wp_q + {1'b0, push};
			rp_q    <= flush ? 2'h0 : rp_q + {1'b0, pop};
			cnt_q   <= cnt_d;
			ready_q <= cnt_d < QUEUE_DEPTH && !flush;
			fetch_q <= fetch_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_a_q <= RST_BYTE;
			acc_b_q <= RST_BYTE;
			reg_x_q <= RST_WORD;
			reg_y_q <= RST_WORD;
			stk_q   <= RST_WORD;
			pc_q    <= RST_WORD;
			flags_q <= RST_FLAGS;
			mode_q  <= MODE_IMPLIED_OPERAND;
			cond_q  <= COND_ALWAYS;
		end else begin
			acc_a_q <= a_d;
			acc_b_q <= b_d;
			reg_x_q <= x_d;
			reg_y_q <= y_d;
			stk_q   <= stk_d;
			pc_q    <= pc_d;
			flags_q <= w_flags ? wd16[7:0] : flags_q;
			mode_q  <= w_ctrl ? avs_writedata[CTL_MODE_LSB +: 3] : mode_q;
			cond_q  <= w_ctrl ? avs_writedata[CTL_COND_LSB +: 3] : cond_q;
		end
	end

	// Done is set by hardware and wins over a clearing go write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q     <= S_IDLE;
			go_q     <= 1'b0;
			done_q   <= 1'b0;
			page2_q  <= 1'b0;
			opc_q    <= RST_BYTE;
			pb_q     <= RST_BYTE;
			opnd_q   <= RST_WORD;
			ea_q     <= RST_WORD;
			indir_q  <= 1'b0;
			branch_q <= 1'b0;
			form_q   <= FORM_REGISTER_OFFSET;
		end else begin
			st_q    <= st_d;
			go_q    <= go_wr | (go_q & ~start & ~flush);
			done_q  <= fin | (done_q & ~go_wr);
			page2_q <= start ? 1'b0
				: (pop && st_q == S_OPC && is_prefix) | page2_q;
			opc_q   <= pop && st_q == S_OPC ? head : opc_q;
			pb_q    <= start ? RST_BYTE
				: pop && st_q == S_POST ? head : pb_q;
			opnd_q  <= opnd_d;
			ea_q    <= fin ? ea_w : ea_q;
			indir_q <= fin ? mode_q == MODE_INDEXED && is_ind : indir_q;
			branch_q <= fin ? cond_w : branch_q;
			form_q  <= fin ? form_d : form_q;
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign prog_ready      = ready_q;
	assign fetch_addr      = fetch_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_QSTART:
	assert property (start |-> cnt_q >= QUEUE_START)
		else $error("decode began with fewer than three bytes");
	AST_ACCPAIR:
	assert property (rd_cap && avs_address == ADDR_ACC
		|=> rdata_q[15:8] == $past(acc_a_q)
		&& rdata_q[7:0] == $past(acc_b_q))
		else $error("accumulator pair read in wrong byte order");
	AST_OFF5:
	assert property (fin && mode_q == MODE_INDEXED && is_off5
		|=> ea_q == $past(base_w) + {{11{$past(pb_q[4])}},
		$past(pb_q[4:0])})
		else $error("five-bit offset address wrong");
	AST_AUTOX:
	assert property (mod_en && rr == 2'h0
		|=> reg_x_q != $past(reg_x_q))
		else $error("auto modify left X unchanged");
	AST_POSTEA:
	assert property (fin && mode_q == MODE_INDEXED && is_post
		|=> ea_q == $past(base_w))
		else $error("post modify used adjusted base");
	AST_NOPCMOD:
	assert property (mod_en |-> rr != 2'h3)
		else $error("pc selected for auto modify");
	AST_PCSTEP:
	assert property (pop |=> pc_q == $past(pc_q) + 16'h0001)
		else $error("pc did not follow consumed byte");
	AST_DIRECT:
	assert property (fin && mode_q == MODE_DIRECT
		|=> ea_q[15:8] == 8'h00)
		else $error("direct address upper byte not zero");
	AST_PREFIX:
	assert property (pop && st_q == S_OPC && is_prefix
		|=> page2_q && st_q == S_OPC)
		else $error("prefix did not select page two");
	AST_HIFIRST:
	assert property (pop && st_q == S_HI_BYTE
		|=> opnd_q[15:8] == $past(head))
		else $error("high byte not taken first");
	AST_INDIR:
	assert property (fin && mode_q == MODE_INDEXED && is_ind
		|=> indir_q && done_q)
		else $error("indirect form not flagged");
	AST_BUS:
	assert property (req && wait_q |=> !wait_q ##1 wait_q)
		else $error("bus answer not after one wait cycle");

	COV_PAGE2:  cover property (fin && page2_q);
	COV_INDIR:  cover property (fin && is_ind && mode_q == MODE_INDEXED);
	COV_POST:   cover property (mod_en && is_post);
	COV_WIDE:   cover property (fin && form_d == FORM_WIDE_OFFSET);

endmodule : ipd_decoder

//--- verif/ipd_prog_mem.sv
// Program memory model feeding the decoder's instruction queue
module ipd_prog_mem (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        slow,
	input  wire logic [15:0] fetch_addr,
	input  wire logic        prog_ready,
	output logic      [7:0]  prog_byte,
	output logic             prog_valid
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] mem [0:65535];
	logic [7:0] last_q;
	int         seed = 32'h9ffa_2f0f;

	// An idle line shows the inverted last byte, never a stale copy
	assign prog_byte = prog_valid ? mem[fetch_addr] : ~last_q;

	// An offer stands until taken; a slow memory drops valid at random
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_valid <= 1'b0;
			last_q     <= 8'h00;
		end else begin
			if (prog_valid && prog_ready)
				last_q <= mem[fetch_addr];
			if (!(prog_valid && !prog_ready))
				prog_valid <= !slow || ($random(seed) & 1);
		end
	end
endmodule : ipd_prog_mem

//--- verif/indexed_postbyte_decoder_test.sv
// Self-checking bench for the indexed postbyte decoder
module indexed_postbyte_decoder_test
	import ipd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  prog_byte;
	logic        prog_valid;
	logic        prog_ready;
	logic        slow = 1'b0;
	logic [15:0] fetch_addr;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          seed = 32'h9ffa_2f0f;
	logic [31:0] rd;
	logic [15:0] xr, yr, sr, ac, pc, pn, base, ea, adj, w;
	logic [7:0]  pb, opc, flg, e1, e2, cv;
	logic [7:0]  q [$];
	int          form, ind, pre, rr, mode, cond;

	ipd_decoder ipd_decoder_i (.clk(clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .prog_byte(prog_byte),
		.prog_valid(prog_valid), .prog_ready(prog_ready),
		.fetch_addr(fetch_addr));
	ipd_prog_mem ipd_prog_mem_i (.clk(clk), .rst_b(rst_b), .slow(slow),
		.fetch_addr(fetch_addr), .prog_ready(prog_ready),
		.prog_byte(prog_byte), .prog_valid(prog_valid));

	always #25 clk = ~clk;

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [15:0] d, input logic [1:0] be);
		int k;
		k = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= {2'b00, be};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 100);
		if (k >= 100)
			error_cnt++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 16'h0000, 2'b11);
		chk(rd, exp);
	endtask : rdchk

	task automatic test_done;
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// Loads registers and bytes, then starts a decode and polls done
	task automatic launch(input logic [2:0] m, input logic [2:0] c);
		int k;
		k = 0;
		for (int i = 0; i < q.size() + 4; i++)
			ipd_prog_mem_i.mem[pc + 16'(i)] = (i < q.size()) ? q[i]
				: 8'($random(seed));
		bus(1'b1, ADDR_IDXX, xr, 2'b11);
		bus(1'b1, ADDR_IDXY, yr, 2'b11);
		bus(1'b1, ADDR_STK, sr, 2'b11);
		bus(1'b1, ADDR_ACC, ac, 2'b11);
		bus(1'b1, ADDR_FLAGS, {8'h00, flg}, 2'b01);
		bus(1'b1, ADDR_PC, pc, 2'b11);
		bus(1'b1, ADDR_CTRL, {7'h00, 1'b1, 1'b0, c, 1'b0, m}, 2'b11);
		do begin
			bus(1'b0, ADDR_STATUS, 16'h0000, 2'b11);
			k++;
		end while (rd[ST_DONE] !== 1'b1 && k < 60);
		if (k >= 60)
			error_cnt++;
		pn = pc + 16'(q.size());
		rdchk(ADDR_FLAGS, {24'h00_0000, flg});
		rdchk(ADDR_PC, {16'h0000, pn});
	endtask : launch

	initial begin
		#3_000_000;
		error_cnt++;
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a <= 36; a += 4)
			rdchk(6'(a), 32'h0000_0000);
		rdchk(6'h3C, 32'h0000_0000);
		bus(1'b1, ADDR_ACC, 16'hA55A, 2'b11);
		bus(1'b1, ADDR_ACC, 16'h1234, 2'b01);
		rdchk(ADDR_ACC, 32'h0000_A534);
		bus(1'b1, ADDR_ACC, 16'hC3FF, 2'b10);
		rdchk(ADDR_ACC, 32'h0000_C334);
		for (int it = 0; it < 48; it++) begin
			slow <= it[0];
			{xr, yr} = $random(seed);
			{sr, ac, pc} = 48'({$random(seed), $random(seed)});
			{pb, opc, flg, e1, e2} = 40'({$random(seed), $random(seed)});
			if (opc == PAGE2_PREFIX)
				opc = 8'h00;
			pre = $random(seed) & 1;
			rr = (pb[7:5] == 3'b111) ? pb[4:3] : pb[7:6];
			form = (pb[7:5] != 3'b111 || pb[2]) ? 0 : pb[1] ? 2 : 1;
			ind = (pb[7:5] == 3'b111 && pb[1:0] == 2'b11);
			q = {};
			if (pre)
				q.push_back(PAGE2_PREFIX);
			q.push_back(opc);
			q.push_back(pb);
			if (form > 0)
				q.push_back(e1);
			if (form > 1)
				q.push_back(e2);
			launch(MODE_INDEXED, 3'h7);
			base = rr == 0 ? xr : rr == 1 ? yr : rr == 2 ? sr : pn;
			adj = pb[3] ? {12'hFFF, pb[3:0]} : 16'(pb[3:0]) + 16'h0001;
			if (pb[7:5] != 3'b111 && !pb[5])
				ea = base + {{11{pb[4]}}, pb[4:0]};
			else if (pb[7:5] != 3'b111) begin
				ea = pb[4] ? base : base + adj;
				xr = rr == 0 ? base + adj : xr;
				yr = rr == 1 ? base + adj : yr;
				sr = rr == 2 ? base + adj : sr;
			end else if (!pb[2])
				ea = base + (pb[1] ? {e1, e2} : {{8{pb[0]}}, e1});
			else
				ea = base + (pb[1:0] == 2'b00 ? {8'h00, ac[15:8]}
					: pb[1:0] == 2'b01 ? {8'h00, ac[7:0]} : ac);
			bus(1'b0, ADDR_STATUS, 16'h0000, 2'b11);
			chk(rd & 32'h00FF_FF77, {8'h00, pb, opc, 1'b0, 2'(form), 2'h0,
				1'(ind), 1'(pre), 1'b1});
			rdchk(ADDR_EA, {16'h0000, ea});
			rdchk(ADDR_IDXX, {16'h0000, xr});
			rdchk(ADDR_IDXY, {16'h0000, yr});
			rdchk(ADDR_STK, {16'h0000, sr});
			if (!it[0]) begin
				chk({16'h0000, fetch_addr}, {16'h0000, pn + 16'h0004});
				chk({31'h0, prog_ready}, 32'h0000_0000);
			end
		end
		for (int it = 0; it < 20; it++) begin
			mode = (it < 5) ? it : 5 + it % 2;
			cond = it % 8;
			{pc, opc, flg} = $random(seed);
			{e1, e2} = 16'($random(seed));
			pre = $random(seed) & 1;
			q = {};
			if (pre)
				q.push_back(PAGE2_PREFIX);
			q.push_back(opc == PAGE2_PREFIX ? 8'h00 : opc);
			if (mode > 0)
				q.push_back(e1);
			if (mode > 0 && mode % 2 == 0)
				q.push_back(e2);
			launch(3'(mode), 3'(cond));
			w = (mode == 0) ? 16'h0000
				: (mode % 2 == 0) ? {e1, e2} : {8'h00, e1};
			cv = {1'b0, ~flg[FLG_C], flg[FLG_C], flg[FLG_V], flg[FLG_N],
				~flg[FLG_Z], flg[FLG_Z], 1'b1};
			if (mode <= 2)
				rdchk(ADDR_OPND, {16'h0000, w});
			else if (mode <= 4)
				rdchk(ADDR_EA, {16'h0000, w});
			else begin
				rdchk(ADDR_EA, {16'h0000, pn + (mode == 5
					? {{8{e1[7]}}, e1} : w)});
				bus(1'b0, ADDR_STATUS, 16'h0000, 2'b11);
				chk({31'h0, rd[ST_BRANCH]}, {31'h0, cv[cond]});
			end
		end
		test_done();
	end
endmodule : indexed_postbyte_decoder_test
